/* File: logic/sopp_host.sv */
// host controller for a 14-bit converter with offset and range flags on a 15-bit bus
// assumes pins synchronous to clk; software reaches it over a plain register port
// Contract
// - host programs offset only within -1310 to +1310
// - offset in low 12 bits, upper 3 bits zero
// - two mode pins pick immediate or deferred update; equal levels forbidden
// - never read during conversion
// - host may hold chip select low and use read alone
// - quiet gap after bus activity before next strobe fall
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "sopp_consts.svh"
module sopp_host
  import sopp_pkg::*;
#(
  parameter int BUSY_TIMEOUT = 64
)
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // software register port
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata_r,
  // converter control pins
  output sopp_pins_type pins_r,
  input wire logic busy_n,
  // converter data bus
  input wire logic [14:0] data_in,
  output logic [14:0] data_out,
  output logic [14:0] data_oe_n
);
  // elaboration check: the wait counter is 8 bits and must outlast one conversion
  if (BUSY_TIMEOUT < `SOPP_CONV_CYC + 2 || BUSY_TIMEOUT > 255)
  begin : g_bad_timeout
    $error("BUSY_TIMEOUT out of range");
  end
  localparam logic [7:0] CONV_CYC = 8'(`SOPP_CONV_CYC);
  localparam logic [7:0] STROBE_CYC = 8'(`SOPP_STROBE_CYC);
  localparam logic [7:0] QUIET_CYC = 8'(`SOPP_QUIET_CYC);
  localparam logic [7:0] RD_CYC = 8'(`SOPP_RD_CYC);
  localparam logic [7:0] TMO_CYC = 8'(BUSY_TIMEOUT);

  sopp_state_type state_r;
  logic [31:0] ctrl_r;
  logic [11:0] shift_r;
  logic shift_err_r;
  logic [7:0] cnt_r;
  logic busy_q_r;
  logic pending_r;
  logic deferred_wait_r;
  logic timeout_r;
  logic [15:0] sample_count_r;
  logic load_r;
  logic [14:0] sample_w;
  sopp_result_type result_w;
  logic go;
  logic wshift_go;
  logic signed [31:0] wsigned;

  assign wsigned = $signed(wdata);
  assign go = wr && addr == `SOPP_REG_CTRL && wdata[`SOPP_CTRL_START];
  assign wshift_go = wr && addr == `SOPP_REG_CTRL && wdata[`SOPP_CTRL_WSHIFT];

  // control register: mode, saturation, continuous run
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ctrl_r <= `SOPP_CTRL_RESET;
    else if (wr && addr == `SOPP_REG_CTRL)
      ctrl_r <= {27'h0, wdata[4:2], 2'b00};
  end

  // offset shadow: out-of-range values refused and flagged
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      shift_r <= 12'h000;
      shift_err_r <= 1'b0;
    end
    else if (wr && addr == `SOPP_REG_SHIFT)
    begin
      if (wsigned >= `SOPP_SHIFT_MIN && wsigned <= `SOPP_SHIFT_MAX)
      begin
        shift_r <= wdata[11:0];
        shift_err_r <= 1'b0;
      end
      else
        shift_err_r <= 1'b1;
    end
  end

  // busy edge tracking
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      busy_q_r <= 1'b1;
    else
      busy_q_r <= busy_n;
  end

  // start and continuous-run requests wait for the sequencer
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pending_r <= 1'b0;
    else if (go || ctrl_r[`SOPP_CTRL_CONT])
      pending_r <= 1'b1;
    else if (state_r == SOPP_STROBE)
      pending_r <= 1'b0;
  end

  // sequencer: strobe, wait busy, read, quiet gap; also owns every pin of the struct
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= SOPP_IDLE;
      cnt_r <= 8'h00;
      pins_r.conversion_strobe_n <= 1'b1;
      pins_r.cs_n <= 1'b1;
      pins_r.rd_n <= 1'b1;
      pins_r.wr_n <= 1'b1;
      timeout_r <= 1'b0;
      deferred_wait_r <= 1'b0;
      load_r <= 1'b0;
      pins_r.mode_low <= 1'b1;
      pins_r.mode_high <= 1'b0;
      pins_r.saturation_enable <= 1'b1;
    end
    else
    begin
      load_r <= 1'b0;
      pins_r.mode_low <= !ctrl_r[`SOPP_CTRL_DEFER]; // never equal
      pins_r.mode_high <= ctrl_r[`SOPP_CTRL_DEFER];
      pins_r.saturation_enable <= ctrl_r[`SOPP_CTRL_SAT];
      unique case (state_r)
        SOPP_IDLE:
        begin
          if (wshift_go)
          begin
            state_r <= SOPP_WRITE;
            cnt_r <= RD_CYC;
            pins_r.cs_n <= 1'b0;
            pins_r.wr_n <= 1'b0; // offset write
          end
          else if (pending_r)
          begin
            state_r <= SOPP_STROBE;
            cnt_r <= STROBE_CYC;
            pins_r.conversion_strobe_n <= 1'b0; // conversion starts
            timeout_r <= 1'b0;
          end
        end
        SOPP_STROBE:
        begin
          if (cnt_r == 8'h01)
          begin
            pins_r.conversion_strobe_n <= 1'b1;
            state_r <= SOPP_WAIT_BUSY;
            cnt_r <= TMO_CYC;
          end
          else
            cnt_r <= cnt_r - 8'h01;
        end
        SOPP_WAIT_BUSY:
        begin
          if (busy_n && !busy_q_r)
          begin
            // read only after busy rises; deferred word is the previous sample
            state_r <= SOPP_READ;
            cnt_r <= RD_CYC;
            pins_r.cs_n <= 1'b0;
            pins_r.rd_n <= 1'b0;
          end
          else if (cnt_r == 8'h00)
          begin
            timeout_r <= 1'b1;
            state_r <= SOPP_QUIET;
            cnt_r <= QUIET_CYC;
          end
          else
            cnt_r <= cnt_r - 8'h01;
        end
        SOPP_READ:
        begin
          if (cnt_r == 8'h01)
          begin
            pins_r.cs_n <= 1'b1;
            pins_r.rd_n <= 1'b1;
            load_r <= 1'b1; // word captured before release
            deferred_wait_r <= ctrl_r[`SOPP_CTRL_DEFER];
            state_r <= SOPP_QUIET;
            cnt_r <= QUIET_CYC;
          end
          else
            cnt_r <= cnt_r - 8'h01;
        end
        SOPP_WRITE:
        begin
          if (cnt_r == 8'h01)
          begin
            pins_r.cs_n <= 1'b1;
            pins_r.wr_n <= 1'b1;
            state_r <= SOPP_QUIET;
            cnt_r <= QUIET_CYC;
          end
          else
            cnt_r <= cnt_r - 8'h01;
        end
        SOPP_QUIET:
        begin
          if (cnt_r <= 8'h01) // gap before next strobe fall
            state_r <= SOPP_IDLE;
          else
            cnt_r <= cnt_r - 8'h01;
        end
      endcase
    end
  end

  // data bus pins; offset placed in low 12 bits, top 3 zero
  sopp_bus_pins u_pins (
    .clk(clk),
    .nrst(nrst),
    .drive(state_r == SOPP_WRITE || (state_r == SOPP_IDLE && wshift_go)),
    .wdata({3'b000, shift_r}),
    .data_in(data_in),
    .data_out(data_out),
    .data_oe_n(data_oe_n),
    .sample_r(sample_w)
  );

  // decode of the captured word by saturation setting
  sopp_decode u_dec (
    .clk(clk),
    .nrst(nrst),
    .load(load_r),
    .word(sample_w),
    .sat(ctrl_r[`SOPP_CTRL_SAT]),
    .result_r(result_w)
  );

  // count of results taken
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      sample_count_r <= 16'h0000;
    else if (load_r)
      sample_count_r <= sample_count_r + 16'h0001;
  end

  // register readback, one cycle after the read strobe
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata_r <= 32'h0000_0000;
    else if (rd)
    begin
      unique case (addr)
        `SOPP_REG_CTRL: rdata_r <= ctrl_r;
        `SOPP_REG_SHIFT: rdata_r <= {{20{shift_r[11]}}, shift_r};
        `SOPP_REG_STATUS: rdata_r <= {26'h0, deferred_wait_r, timeout_r, shift_err_r, pending_r,
          state_r != SOPP_IDLE, result_w.range_flag_bit};
        `SOPP_REG_RESULT: rdata_r <= {14'h0, result_w.range_flag_bit, result_w.range_side_bit,
          result_w.value};
        `SOPP_REG_COUNT: rdata_r <= {16'h0, sample_count_r};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
    else
      rdata_r <= 32'h0000_0000;
  end

  property p_mode_pins_differ;
    @(posedge clk) disable iff (!nrst) pins_r.mode_low != pins_r.mode_high;
  endproperty
  a_mode_pins_differ: assert property (p_mode_pins_differ) else $error("mode pins equal");

  property p_no_read_in_conv;
    @(posedge clk) disable iff (!nrst) !busy_n |-> pins_r.rd_n;
  endproperty
  a_no_read_in_conv: assert property (p_no_read_in_conv) else $error("read during conversion");

  property p_read_selects;
    @(posedge clk) disable iff (!nrst) !pins_r.rd_n |-> !pins_r.cs_n;
  endproperty
  a_read_selects: assert property (p_read_selects) else $error("read without chip select");

  property p_quiet_gap;
    @(posedge clk) disable iff (!nrst) $rose(pins_r.cs_n) |-> pins_r.conversion_strobe_n [*4];
  endproperty
  a_quiet_gap: assert property (p_quiet_gap) else $error("strobe inside quiet gap");

  property p_write_top_zero;
    @(posedge clk) disable iff (!nrst) data_oe_n == 15'h0000 |-> data_out[14:12] == 3'b000;
  endproperty
  a_write_top_zero: assert property (p_write_top_zero) else $error("offset top bits set");

  property p_shift_range;
    @(posedge clk) disable iff (!nrst) $signed(shift_r) >= -12'sd1310 && $signed(shift_r) <= 12'sd1310;
  endproperty
  a_shift_range: assert property (p_shift_range) else $error("offset out of range");

  property p_strobe_single;
    @(posedge clk) disable iff (!nrst) $fell(pins_r.conversion_strobe_n) |=> pins_r.conversion_strobe_n;
  endproperty
  a_strobe_single: assert property (p_strobe_single) else $error("strobe width wrong");

  property p_read_after_busy;
    @(posedge clk) disable iff (!nrst) $fell(pins_r.rd_n) |-> $past(busy_n) && !$past(busy_q_r);
  endproperty
  a_read_after_busy: assert property (p_read_after_busy) else $error("read not after busy rise");

  property p_sat_clamp;
    @(posedge clk) disable iff (!nrst) $past(load_r) && $past(ctrl_r[`SOPP_CTRL_SAT]) |->
      result_w.value <= 16'sh3FFF && result_w.value >= 16'sh0000;
  endproperty
  a_sat_clamp: assert property (p_sat_clamp) else $error("clamped value out of range");

  c_conv: cover property (@(posedge clk) disable iff (!nrst) $fell(pins_r.conversion_strobe_n));
  c_read: cover property (@(posedge clk) disable iff (!nrst) load_r);
  c_write: cover property (@(posedge clk) disable iff (!nrst) $fell(pins_r.wr_n));
  c_timeout: cover property (@(posedge clk) disable iff (!nrst) $rose(timeout_r));
endmodule

/* File: logic/sopp_consts.svh */
// constants for the converter host controller: register offsets, fields, timing
// assumes a 40 MHz clk; included by bare name
`ifndef SOPP_CONSTS_SVH
`define SOPP_CONSTS_SVH
// host register offsets (word index on the plain port)
`define SOPP_REG_CTRL 4'h0
`define SOPP_REG_SHIFT 4'h1
`define SOPP_REG_STATUS 4'h2
`define SOPP_REG_RESULT 4'h3
`define SOPP_REG_COUNT 4'h4
// control register fields
`define SOPP_CTRL_START 0
`define SOPP_CTRL_WSHIFT 1
`define SOPP_CTRL_DEFER 2
`define SOPP_CTRL_SAT 3
`define SOPP_CTRL_CONT 4
`define SOPP_CTRL_RESET 32'h0000_0000
// offset limits and field width
`define SOPP_SHIFT_MIN (-1310)
`define SOPP_SHIFT_MAX 1310
`define SOPP_SHIFT_W 12
// timing, ns, and derived cycles at 25 ns
`define SOPP_CLK_NS 25
`define SOPP_CONV_NS 300
`define SOPP_STROBE_NS 25
`define SOPP_QUIET_NS 100
`define SOPP_RD_NS 50
`define SOPP_CONV_CYC ((`SOPP_CONV_NS + `SOPP_CLK_NS - 1) / `SOPP_CLK_NS)
`define SOPP_STROBE_CYC ((`SOPP_STROBE_NS + `SOPP_CLK_NS - 1) / `SOPP_CLK_NS)
`define SOPP_QUIET_CYC ((`SOPP_QUIET_NS + `SOPP_CLK_NS - 1) / `SOPP_CLK_NS)
`define SOPP_RD_CYC ((`SOPP_RD_NS + `SOPP_CLK_NS - 1) / `SOPP_CLK_NS)
`endif

/* File: logic/sopp_pkg.sv */
// types for the converter host controller
// shared by the controller, its decoder and the converter model
package sopp_pkg;
  typedef enum logic [2:0] {SOPP_IDLE, SOPP_STROBE, SOPP_WAIT_BUSY, SOPP_READ, SOPP_WRITE, SOPP_QUIET}
    sopp_state_type;
  // pins toward the converter
  typedef struct packed {
    logic conversion_strobe_n;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic mode_low;
    logic mode_high;
    logic saturation_enable;
  } sopp_pins_type;
  // decoded conversion result
  typedef struct packed {
    logic range_flag_bit;
    logic range_side_bit;
    logic signed [15:0] value;
  } sopp_result_type;
endpackage

/* File: logic/sopp_decode.sv */
// decoder turning a 15-bit bus word into a signed value and range flags
// assumes the word was captured with the saturation setting given beside it
`timescale 1ns/1ps
module sopp_decode
  import sopp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // captured word
  input wire logic load,
  input wire logic [14:0] word,
  input wire logic sat,
  // decoded result, registered
  output sopp_result_type result_r
);
  logic signed [15:0] val_nxt;
  // value decode by saturation and side bits
  always_comb
  begin
    if (sat || !word[14])
      val_nxt = {1'b0, (sat ? {1'b0, word[13:0]} : word)};
    else if (word[13])
      val_nxt = {word[14], word}; // negative two's complement
    else
      val_nxt = {1'b0, word}; // straight binary above range
  end
  // result register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      result_r <= '0;
    else if (load)
      result_r <= '{range_flag_bit: word[14], range_side_bit: word[13], value: val_nxt};
  end
endmodule

/* File: logic/sopp_bus_pins.sv */
// pin driver for the converter's 15-bit two-way data bus
// assumes the converter drives only while both selects are low
`timescale 1ns/1ps
module sopp_bus_pins
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // write request
  input wire logic drive,
  input wire logic [14:0] wdata,
  // pins
  input wire logic [14:0] data_in,
  output logic [14:0] data_out,
  output logic [14:0] data_oe_n,
  // sampled read word
  output logic [14:0] sample_r
);
  // drive only for an offset write; enable low while driving
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      data_out <= 15'h0000;
      data_oe_n <= 15'h7FFF;
    end
    else
    begin
      data_out <= drive ? wdata : 15'h0000;
      data_oe_n <= drive ? 15'h0000 : 15'h7FFF;
    end
  end
  // sample the bus every cycle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      sample_r <= 15'h0000;
    else
      sample_r <= data_in;
  end
endmodule

/* File: verification/sopp_conv_model.sv */
// behavioural model of the converter facing the host controller
// assumes pins registered on clk; vin is the sampled input in code steps
`timescale 1ns/1ps
`include "sopp_consts.svh"
module sopp_conv_model
  import sopp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // from the host, and the sampled input
  input sopp_pins_type pins,
  input wire logic [14:0] bus,
  input wire logic signed [15:0] vin,
  // toward the host
  output logic busy_n,
  output logic [14:0] dev_q,
  // count of host misbehaviour
  output logic [7:0] err_cnt
);
  logic [14:0] out_r, sar_r, last_r;
  logic [11:0] shift_r;
  logic signed [15:0] held_r;
  logic [3:0] cnt_r;
  logic [7:0] gap_r, bad;
  logic strobe_d_r;
  wire defer = pins.mode_high & ~pins.mode_low;
  wire drive = ~pins.cs_n & ~pins.rd_n;
  wire fall = strobe_d_r & ~pins.conversion_strobe_n;
  // offset add, then clamp and flag on the adjusted sum when saturating
  function automatic logic [14:0] conv_code(input logic signed [15:0] v, input logic signed [11:0] o, input logic s);
    logic signed [16:0] t;
    t = v + o;
    if (!s) return t[14:0];
    if (t < 0) return 15'h4000;
    if (t > 17'sd16383) return 15'h7FFF;
    return {1'b0, t[13:0]};
  endfunction
  // released bus shows a toggling pattern, never the last word
  assign dev_q = drive ? out_r : ~last_r;
  // host misbehaviour seen this cycle
  always_comb
  begin
    bad = 8'h00;
    if (pins.mode_low == pins.mode_high) bad = bad + 8'h01;
    if (drive && !busy_n) bad = bad + 8'h01;
    if (fall && gap_r < `SOPP_QUIET_CYC) bad = bad + 8'h01;
    if (!pins.cs_n && !pins.wr_n && (bus[14:12] != 3'h0 || $signed(bus[11:0]) < -1310 || $signed(bus[11:0]) > 1310))
      bad = bad + 8'h01;
  end
  // conversion timing, output register and offset store
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_n <= 1'b1;
      cnt_r <= 4'h0;
      shift_r <= 12'h000;
      out_r <= 15'h0000;
      sar_r <= 15'h0000;
      held_r <= 16'sh0000;
      last_r <= 15'h0000;
      gap_r <= 8'hFF;
      strobe_d_r <= 1'b1;
      err_cnt <= 8'h00;
    end
    else
    begin
      strobe_d_r <= pins.conversion_strobe_n;
      last_r <= dev_q;
      gap_r <= !pins.cs_n ? 8'h00 : (gap_r == 8'hFF ? gap_r : gap_r + 8'h01);
      err_cnt <= err_cnt + bad;
      if (fall)
      begin
        busy_n <= 1'b0;
        cnt_r <= 4'(`SOPP_CONV_CYC);
        held_r <= vin;
        if (defer)
          out_r <= sar_r;
      end
      else if (cnt_r != 4'h0)
      begin
        cnt_r <= cnt_r - 4'h1;
        if (cnt_r == 4'h1)
        begin
          busy_n <= 1'b1;
          sar_r <= conv_code(held_r, shift_r, pins.saturation_enable);
          if (!defer)
            out_r <= conv_code(held_r, shift_r, pins.saturation_enable);
        end
      end
      if (!pins.cs_n && !pins.wr_n)
        shift_r <= bus[11:0];
    end
  end
endmodule

/* File: verification/sar_adc_offset_range_parallel_port_tb.sv */
// self-checking bench for the converter host controller
// assumes the converter model on the far side, 40 MHz clk
`timescale 1ns/1ps
`include "sopp_consts.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; $display("unexpected at %0t: got %h want %h", $time, (g), (e)); end end
module sar_adc_offset_range_parallel_port_tb
  import sopp_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata_r;
  sopp_pins_type pins_r;
  logic busy_n;
  logic [14:0] data_in, data_out, data_oe_n, dev_q;
  logic signed [15:0] vin = 16'sh0000;
  logic [7:0] merr;
  int n_errors = 0;
  int total_checks = 0;
  logic [15:0] seed = 16'h0053;
  logic [14:0] prev_w = 15'h0000;
  int exp_count = 0;
  logic sat = 1'b1;
  logic defer = 1'b0;
  logic signed [11:0] off = 12'sh000;
  localparam int c_vin [8] = '{16600, -150, 8000, 16000, 200, 16384, -200, 1000};
  localparam int c_off [8] = '{0, 0, 0, 1000, -512, 1024, -1310, 1310};
  localparam bit c_sat [8] = '{1, 1, 1, 1, 1, 0, 0, 0};
  // each bus line is driven by the host when enabled, else by the converter
  assign data_in = (~data_oe_n & data_out) | (data_oe_n & dev_q);
  sopp_host #(.BUSY_TIMEOUT(64)) uut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_r(rdata_r), .pins_r(pins_r), .busy_n(busy_n), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n));
  sopp_conv_model dev (.clk(clk), .nrst(nrst), .pins(pins_r), .bus(data_in), .vin(vin), .busy_n(busy_n),
    .dev_q(dev_q), .err_cnt(merr));
  // clock
  initial
    forever #12.5 clk = ~clk;
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [31:0] ctl(input logic d, input logic s, input logic [31:0] p);
    ctl = p;
    ctl[`SOPP_CTRL_DEFER] = d;
    ctl[`SOPP_CTRL_SAT] = s;
  endfunction
  // expected decoded result of a bus word
  function automatic logic [17:0] dec(input logic [14:0] w);
    return {w[14], w[13], sat ? {2'b00, w[13:0]} : {w[14] & w[13], w}};
  endfunction
  // expected bus word: offset add, then clamp and flag when saturating
  function automatic logic [14:0] exp_code(input int v, input int o, input logic s);
    int t;
    t = v + o;
    if (!s)
      return 15'(t);
    if (t < 0)
      return 15'h4000;
    if (t > 16383)
      return 15'h7FFF;
    return 15'(t);
  endfunction
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [3:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata_r;
    @(posedge clk);
  endtask
  task automatic wait_idle;
    logic [31:0] s;
    int i;
    repeat (3) @(posedge clk);
    for (i = 0; i < 100; i++)
    begin
      rreg(`SOPP_REG_STATUS, s);
      if (s[2:1] == 2'b00)
        break;
    end
    if (i == 100)
    begin
      n_errors++;
      $display("unexpected at %0t: sequencer stuck", $time);
      report_and_stop();
    end
  endtask
  task automatic set_off(input int o);
    wreg(`SOPP_REG_SHIFT, o);
    wreg(`SOPP_REG_CTRL, ctl(defer, sat, 32'h1 << `SOPP_CTRL_WSHIFT));
    wait_idle();
    if (o >= `SOPP_SHIFT_MIN && o <= `SOPP_SHIFT_MAX)
      off = 12'(o);
  endtask
  task automatic convert(input int v);
    logic [31:0] r;
    logic [14:0] w;
    logic [17:0] m;
    vin <= 16'(v);
    wreg(`SOPP_REG_CTRL, ctl(defer, sat, 32'h1 << `SOPP_CTRL_START));
    wait_idle();
    rreg(`SOPP_REG_RESULT, r);
    w = exp_code(v, off, sat);
    m = sat ? 18'h2FFFF : 18'h3FFFF;
    `CHK(r[17:0] & m, dec(defer ? prev_w : w) & m)
    prev_w = w;
    exp_count++;
    rreg(`SOPP_REG_COUNT, r);
    `CHK(r, 32'(exp_count))
  endtask
  // main sequence
  initial
  begin
    logic [31:0] r;
    int i;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rreg(`SOPP_REG_CTRL, r);
    `CHK(r, 32'h0)
    rreg(`SOPP_REG_SHIFT, r);
    `CHK(r, 32'h0)
    rreg(`SOPP_REG_COUNT, r);
    `CHK(r, 32'h0)
    rreg(4'hF, r);
    `CHK(r, 32'h0)
    $display("test reset done");
    wreg(`SOPP_REG_CTRL, ctl(1'b0, 1'b1, 32'h0));
    for (i = 0; i < 14; i++)
    begin
      if (i < 8)
      begin
        sat = c_sat[i];
        set_off(c_off[i]);
        convert(c_vin[i]);
      end
      else
      begin
        seed = lfsr(seed);
        sat = seed[0];
        set_off(int'(seed % 16'd2621) - 1310);
        seed = lfsr(seed);
        convert(int'(seed % 16'd19000) - 1200);
      end
    end
    $display("test offset and range done");
    set_off(1311);
    rreg(`SOPP_REG_STATUS, r);
    `CHK(r[3], 1'b1)
    convert(500);
    $display("test offset refusal done");
    defer = 1'b1;
    sat = 1'b0;
    wreg(`SOPP_REG_CTRL, ctl(defer, sat, 32'h0));
    convert(3000);
    convert(17000);
    rreg(`SOPP_REG_STATUS, r);
    `CHK(r[5:4], 2'b10)
    defer = 1'b0;
    wreg(`SOPP_REG_CTRL, ctl(defer, sat, 32'h0));
    convert(-100);
    $display("test deferred mode done");
    // continuous run: six strobes fit before the stop takes hold
    wreg(`SOPP_REG_CTRL, ctl(defer, sat, 32'h1 << `SOPP_CTRL_CONT));
    repeat (100) @(posedge clk);
    wreg(`SOPP_REG_CTRL, ctl(defer, sat, 32'h0));
    wait_idle();
    rreg(`SOPP_REG_COUNT, r);
    `CHK((r - 32'(exp_count)) inside {[32'd5:32'd7]}, 1'b1)
    $display("test continuous run done");
    `CHK(merr, 8'h00)
    report_and_stop();
  end
endmodule
